// ### rtl/fdcr_pkg.sv
// Package for the floppy drive control register bank.
package fdcr_pkg;

  // ==========================================================================
  // Register map (byte-wide I/O ports, primary addresses)
  // ==========================================================================
  localparam logic [9:0] STATUS_B_ADDR   = 10'h3f1;
  localparam logic [9:0] DRV_CTRL_ADDR   = 10'h3f2;
  localparam logic [9:0] TAPE_SEL_ADDR   = 10'h3f3;
  localparam logic [9:0] DIG_INPUT_ADDR  = 10'h3f7;

  // ==========================================================================
  // Field positions of the drive control register
  // ==========================================================================
  localparam int unsigned DC_SEL_LSB   = 0;
  localparam int unsigned DC_RESET_BIT = 2;
  localparam int unsigned DC_DMA_BIT   = 3;
  localparam int unsigned DC_MOTOR_LSB = 4;

  // ==========================================================================
  // Field positions of status B
  // ==========================================================================
  localparam int unsigned SB_WRITE_ENABLE_TO_DRIVE_BIT  = 2;
  localparam int unsigned SB_RTOG_BIT   = 3;
  localparam int unsigned SB_WTOG_BIT   = 4;
  localparam int unsigned SB_SEL0_BIT   = 5;
  localparam int unsigned TAPE_SEL_BITS = 2;

  // ==========================================================================
  // Values after reset
  // ==========================================================================
  localparam logic [7:0] DRV_CTRL_RST    = 8'h00;
  localparam logic [1:0] TAPE_SEL_RST    = 2'h0;
  localparam logic [1:0] SB_RSVD_ONES    = 2'h3;
  localparam logic [3:0] SEL_N_IDLE      = 4'hf;
  localparam logic [3:0] MOTOR_N_IDLE    = 4'hf;
  localparam logic [7:0] TAPE_RD_OE      = 8'h03;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned SRST_MIN_NS    = 100;
  localparam int unsigned SRST_CYC_INT   =
    (SRST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  SRST_CYC       = SRST_CYC_INT[3:0];

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    NATIVE_STATUS_MODE,
    COMPACT_STATUS_MODE,
    PLAIN_MODE
  } fdcr_mode_t;

  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic       rd;
    logic       wr;
  } fdcr_bus_req_t;

  typedef struct packed {
    logic [3:0] drive_select_n;
    logic [3:0] motor_on_n;
  } fdcr_drive_pins_t;

endpackage

// ### rtl/fdcr_edge_sync.sv
// Optional two-stage synchroniser with rise detection for one signal.
`timescale 1ns/1ps
`default_nettype none
module fdcr_edge_sync #(
  parameter bit SYNC = 1'b1
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic sig_i,
  output var  logic level_o,
  output var  logic rise_o
);

  // ==========================================================================
  // Stages
  // ==========================================================================
  logic meta;
  logic stable;
  logic prev;

  // First stage feeds only the second, so metastability never spreads.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta   <= 1'b1;
      stable <= 1'b1;
    end else begin
      meta   <= sig_i;
      stable <= meta;
    end
  end

  // Same-clock signals skip the synchroniser to save two cycles of lag.
  always_comb begin
    level_o = SYNC ? stable : sig_i;
  end

  // Previous level for edge detection.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev <= 1'b1;
    end else begin
      prev <= level_o;
    end
  end

  // A rise is a low-to-high change of the qualified level.
  always_comb begin
    rise_o = level_o & ~prev;
  end

endmodule
`default_nettype wire

// ### rtl/fdcr_regs.sv
// Drive control, tape select and status B registers of a floppy controller.
//
// Functional notes
// - native status bits 1:0 show motors 1:0
// - native status bit 2 shows write enable
// - native bit 3 toggles on read-pulse rise
// - native bit 4 toggles on write-pulse rise
// - native bit 5 mirrors drive control bit 0
// - native bits 7:6 always read one
// - compact mode reports selects and second drive
// - compact bit 2 latches write enable rise
// - compact bit 3 latches read-pulse rise
// - compact bit 4 latches write-pulse rise
// - drive control always writable, kept on soft reset
// - bits 1:0 pick at most one drive
// - bit 2 low holds controller in reset
// - soft reset stretched to at least 100ns
// - bit 3 gates DMA pins outside native
// - native mode keeps DMA pins always enabled
// - bits 7:4 drive active-low motor outputs
// - normal decode needs matching motor bit set
// - swapped decode exchanges drives 0 and 1
// - tape select stored only, upper bits float
// - two tape bits encode tape drive
// - plain mode status B read floats bus
// - digital input read clears compact latches
`timescale 1ns/1ps
`default_nettype none
module fdcr_regs (
  input  wire logic                      clk_i,
  input  wire logic                      rstn_i,
  input  wire fdcr_pkg::fdcr_bus_req_t   bus_i,
  input  wire fdcr_pkg::fdcr_mode_t      status_mode_i,
  input  wire logic                      swap_drives_i,
  input  wire logic                      write_enable_to_drive_i,
  input  wire logic                      write_pulse_n_i,
  input  wire logic                      read_pulse_n_i,
  input  wire logic                      second_drive_present_n_i,
  output var  logic [7:0]                rdata_o,
  output var  logic [7:0]                rdata_oe_o,
  output var  fdcr_pkg::fdcr_drive_pins_t drive_pins_o,
  output var  logic                      soft_reset_n_o,
  output var  logic                      dma_pins_en_o,
  output var  logic [1:0]                tape_select_o
);
  import fdcr_pkg::*;

  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [7:0]       drive_output_control;
  logic [1:0]       tape_select_reg;
  logic [3:0]       srst_cnt;
  logic             rtog;
  logic             wtog;
  logic             write_enable_to_drive_ff;
  logic             rdata_ff;
  logic             wdata_ff;
  fdcr_drive_pins_t next_pins;
  logic [7:0]       status_b;
  logic             rd_rise;
  logic             wp_rise;
  logic             we_rise;
  logic             drv2_n;
  logic             wr_dc;
  logic             wr_tape;
  logic             rd_dir;

  // ==========================================================================
  // Pin conditioning
  // ==========================================================================
  // The read pulse comes from the drive and must be synchronised first.
  fdcr_edge_sync #(.SYNC(1'b1)) u_read_pulse (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .sig_i   (read_pulse_n_i),
    .level_o (),
    .rise_o  (rd_rise)
  );

  // The drive-present strap is a slow pin level.
  fdcr_edge_sync #(.SYNC(1'b1)) u_drive_present (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .sig_i   (second_drive_present_n_i),
    .level_o (drv2_n),
    .rise_o  ()
  );

  // Write pulse is produced by the controller core on this clock.
  fdcr_edge_sync #(.SYNC(1'b0)) u_write_pulse (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .sig_i   (write_pulse_n_i),
    .level_o (),
    .rise_o  (wp_rise)
  );

  // Write enable is same-clock and active high; its active edge is a rise.
  // The previous level resets to the idle low, so reset makes no edge.
  logic we_prev;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      we_prev <= 1'b0;
    end else begin
      we_prev <= write_enable_to_drive_i;
    end
  end
  assign we_rise = write_enable_to_drive_i & ~we_prev;

  // ==========================================================================
  // Address decode
  // ==========================================================================
  assign wr_dc   = bus_i.wr && (bus_i.addr == DRV_CTRL_ADDR);
  assign wr_tape = bus_i.wr && (bus_i.addr == TAPE_SEL_ADDR);
  assign rd_dir  = bus_i.rd && (bus_i.addr == DIG_INPUT_ADDR);

  // ==========================================================================
  // Drive control register
  // ==========================================================================
  // writable any time
  // Only the hardware reset clears it; the soft reset never touches it.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      drive_output_control <= DRV_CTRL_RST;
    end else if (wr_dc) begin
      drive_output_control <= bus_i.wdata;
    end
  end

  // stretch to minimum
  // Back-to-back clear/set writes last one cycle, far below the minimum,
  // so the released edge is delayed by a counter.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      srst_cnt       <= SRST_CYC;
      soft_reset_n_o <= 1'b0;
    end else begin
      if (!drive_output_control[DC_RESET_BIT]) begin
        srst_cnt <= SRST_CYC;
      end else if (srst_cnt != 4'h0) begin
        srst_cnt <= srst_cnt - 4'h1;
      end
      soft_reset_n_o <= drive_output_control[DC_RESET_BIT] &&
                        (srst_cnt == 4'h0);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dma_pins_en_o <= 1'b0;
    end else begin
      dma_pins_en_o <= (status_mode_i == NATIVE_STATUS_MODE) ||
                       drive_output_control[DC_DMA_BIT];
    end
  end

  // ==========================================================================
  // Drive decode
  // ==========================================================================
  // one-hot select decode
  function automatic fdcr_drive_pins_t decode(input logic [7:0] dc,
                                              input logic       swap);
    logic [3:0] mot;
    logic [1:0] code;
    mot  = dc[DC_MOTOR_LSB +: 4];
    code = dc[DC_SEL_LSB +: 2];
    if (swap) begin
      mot  = {mot[3:2], mot[0], mot[1]};
      code = (code[1] == 1'b0) ? {1'b0, ~code[0]} : code;
    end
    decode.motor_on_n     = ~mot;
    decode.drive_select_n = SEL_N_IDLE;
    if (mot[code]) begin
      decode.drive_select_n[code] = 1'b0;
    end
  endfunction

  assign next_pins = decode(drive_output_control, swap_drives_i);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      drive_pins_o <= '{drive_select_n: SEL_N_IDLE, motor_on_n: MOTOR_N_IDLE};
    end else begin
      drive_pins_o <= next_pins;
    end
  end

  // ==========================================================================
  // Tape select register
  // ==========================================================================
  // stored for readback
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tape_select_reg <= TAPE_SEL_RST;
    end else if (wr_tape) begin
      tape_select_reg <= bus_i.wdata[TAPE_SEL_BITS-1:0];
    end
  end
  assign tape_select_o = tape_select_reg;

  // ==========================================================================
  // Status B flags
  // ==========================================================================
  // read and write toggles
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rtog <= 1'b0;
      wtog <= 1'b0;
    end else begin
      rtog <= rtog ^ rd_rise;
      wtog <= wtog ^ wp_rise;
    end
  end

  // latch write enable, read pulse and write pulse rises
  // A new edge in the cycle of the clearing read wins over the clear.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      write_enable_to_drive_ff <= 1'b0;
      rdata_ff <= 1'b0;
      wdata_ff <= 1'b0;
    end else begin
      write_enable_to_drive_ff <= we_rise | (write_enable_to_drive_ff & ~rd_dir);
      rdata_ff <= rd_rise | (rdata_ff & ~rd_dir);
      wdata_ff <= wp_rise | (wdata_ff & ~rd_dir);
    end
  end

  // Status B content by mode.
  always_comb begin
    if (status_mode_i == COMPACT_STATUS_MODE) begin
      status_b = {drv2_n, drive_pins_o.drive_select_n[1:0],
                  wdata_ff, rdata_ff, write_enable_to_drive_ff,
                  drive_pins_o.drive_select_n[3:2]};
    end else begin
      status_b = {SB_RSVD_ONES, drive_output_control[DC_SEL_LSB],
                  wtog, rtog, write_enable_to_drive_i,
                  ~drive_pins_o.motor_on_n[1:0]};
    end
  end

  // ==========================================================================
  // Read port
  // ==========================================================================
  // Read data answers one cycle after the strobe and stands one cycle.
  // Unmapped addresses and the digital input port leave the bus floating.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o    <= 8'h00;
      rdata_oe_o <= 8'h00;
    end else begin
      rdata_o    <= 8'h00;
      rdata_oe_o <= 8'h00;
      if (bus_i.rd) begin
        case (bus_i.addr)
          STATUS_B_ADDR: begin
            if (status_mode_i != PLAIN_MODE) begin
              rdata_o    <= status_b;
              rdata_oe_o <= 8'hff;
            end
          end
          DRV_CTRL_ADDR: begin
            rdata_o    <= drive_output_control;
            rdata_oe_o <= 8'hff;
          end
          TAPE_SEL_ADDR: begin
            rdata_o    <= {6'h00, tape_select_reg};
            rdata_oe_o <= TAPE_RD_OE;
          end
          default: ;
        endcase
      end
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  srst_stretch_a: assert property (
    $fell(soft_reset_n_o) |-> !soft_reset_n_o [*8] ##1 !soft_reset_n_o [*2])
    else $error("soft reset released too early");
  srst_hold_a: assert property (
    !drive_output_control[DC_RESET_BIT] |=> !soft_reset_n_o)
    else $error("soft reset not held");
  dma_native_a: assert property (
    status_mode_i == NATIVE_STATUS_MODE && $stable(status_mode_i)
    |=> dma_pins_en_o)
    else $error("dma pins disabled in native mode");
  dma_gate_a: assert property (
    status_mode_i != NATIVE_STATUS_MODE &&
    !drive_output_control[DC_DMA_BIT] |=> !dma_pins_en_o)
    else $error("dma pins enabled without gate bit");
  sel_onehot_a: assert property (
    $countones(~drive_pins_o.drive_select_n) <= 1)
    else $error("more than one drive selected");
  sel_motor_a: assert property (
    wr_dc && bus_i.wdata == 8'h1c && !swap_drives_i
    |=> ##1 drive_pins_o.drive_select_n == 4'he &&
        drive_pins_o.motor_on_n == 4'he)
    else $error("drive 0 activation decode wrong");
  swap_sel_a: assert property (
    wr_dc && bus_i.wdata == 8'h1c && swap_drives_i
    |=> ##1 drive_pins_o.drive_select_n == 4'hd &&
        drive_pins_o.motor_on_n == 4'hd)
    else $error("swapped decode wrong");
  plain_float_a: assert property (
    bus_i.rd && bus_i.addr == STATUS_B_ADDR &&
    status_mode_i == PLAIN_MODE |=> rdata_oe_o == 8'h00)
    else $error("status B driven in plain mode");
  rsvd_ones_a: assert property (
    bus_i.rd && bus_i.addr == STATUS_B_ADDR &&
    status_mode_i == NATIVE_STATUS_MODE |=> rdata_o[7:6] == 2'b11)
    else $error("reserved bits not one");
  latch_clear_a: assert property (
    rd_dir && !rd_rise |=> !rdata_ff)
    else $error("read latch not cleared");
  set_wins_a: assert property (
    rd_dir && we_rise |=> write_enable_to_drive_ff)
    else $error("write enable edge lost on clear");
  tape_oe_a: assert property (
    bus_i.rd && bus_i.addr == TAPE_SEL_ADDR |=> rdata_oe_o == TAPE_RD_OE)
    else $error("tape select upper bits driven");

  soft_reset_c: cover property ($rose(soft_reset_n_o));
  swap_use_c: cover property (swap_drives_i && !drive_pins_o.drive_select_n[1]);
  compact_rd_c: cover property (rd_dir && wdata_ff);
  rtog_c: cover property ($rose(rtog));

endmodule
`default_nettype wire

// ### test/fdcr_drive_model.sv
// Behavioural floppy drive that answers the register bank's drive pins.
`timescale 1ns/1ps
`default_nettype none
module fdcr_drive_model #(
  parameter int unsigned DRIVE = 0
) (
  input  wire logic        clk_i,
  input  wire logic [3:0]  drive_select_n_i,
  input  wire logic [3:0]  motor_on_n_i,
  input  wire logic        spin_i,
  input  wire logic        slow_i,
  input  wire logic        present_i,
  output var  logic        read_pulse_n_o,
  output var  logic        second_drive_present_n_o,
  output var  int unsigned rise_count_o
);
  logic [4:0]  phase = 5'h00;
  logic        prev  = 1'b1;
  int unsigned cnt   = 0;
  wire logic   active = spin_i && !drive_select_n_i[DRIVE] &&
                        !motor_on_n_i[DRIVE];

  // Flux only arrives while selected and spinning; the pulled-up line
  // idles high otherwise, so a stop mid-pulse still gives a rise.
  always_ff @(posedge clk_i) begin
    phase <= (!active || phase == (slow_i ? 5'h1f : 5'h05)) ? 5'h00
             : phase + 5'h01;
    prev <= read_pulse_n_o;
    if (!prev && read_pulse_n_o) begin
      cnt <= cnt + 1;
    end
  end

  // Low for two cycles per bit cell; rises are counted for the bench.
  assign read_pulse_n_o           = !(active && phase < 5'h02);
  assign second_drive_present_n_o = !present_i;
  assign rise_count_o             = cnt;
endmodule
`default_nettype wire

// ### test/tb_floppy_drive_control_regs.sv
// Self-checking bench for the floppy drive control register bank.
`timescale 1ns/1ps
`default_nettype none
module tb_floppy_drive_control_regs;
  import fdcr_pkg::*;
  logic             clk = 1'b0;
  logic             rstn = 1'b0;
  fdcr_bus_req_t    bus = '0;
  fdcr_mode_t       mode = NATIVE_STATUS_MODE;
  logic             swap = 1'b0;
  logic             we = 1'b0;
  logic             wp_n = 1'b1;
  logic             spin = 1'b0;
  logic             slow = 1'b0;
  logic             present = 1'b0;
  wire logic        rp_n;
  wire logic        pres_n;
  logic [7:0]       rdata;
  logic [7:0]       oe;
  fdcr_drive_pins_t pins;
  logic             srst_n;
  logic             dma_en;
  logic [1:0]       tape;
  int unsigned      rcount;
  int               bad_count = 0;
  int               n_checks = 0;
  int               lo;
  logic [7:0]       e;
  logic [7:0]       act [8] = '{8'h1c, 8'h2d, 8'h4e, 8'h8f,
                                8'h0c, 8'h1d, 8'h6d, 8'hf7};

  fdcr_regs uut (
    .clk_i(clk), .rstn_i(rstn), .bus_i(bus), .status_mode_i(mode),
    .swap_drives_i(swap), .write_enable_to_drive_i(we),
    .write_pulse_n_i(wp_n), .read_pulse_n_i(rp_n),
    .second_drive_present_n_i(pres_n), .rdata_o(rdata),
    .rdata_oe_o(oe), .drive_pins_o(pins), .soft_reset_n_o(srst_n),
    .dma_pins_en_o(dma_en), .tape_select_o(tape));

  fdcr_drive_model drive0 (
    .clk_i(clk), .drive_select_n_i(pins.drive_select_n),
    .motor_on_n_i(pins.motor_on_n), .spin_i(spin), .slow_i(slow),
    .present_i(present), .read_pulse_n_o(rp_n),
    .second_drive_present_n_o(pres_n), .rise_count_o(rcount));

  // ==========================================================================
  // Clock and helpers
  // ==========================================================================
  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk = ~clk;
  end

  // Inputs move 1 ns after an edge so no race with the sampling edge.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Write strobe is high for exactly one cycle; an idle edge follows so
  // the next call never raises the strobe in the step that lowered it.
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    bus.addr  = a;
    bus.wdata = d;
    bus.wr    = 1'b1;
    tick(1);
    bus.wr    = 1'b0;
    tick(1);
  endtask

  // Read data stands for the single cycle after the strobe.
  task automatic rd(input logic [9:0] a, input logic [7:0] exp,
                    input logic [7:0] eoe);
    bus.addr = a;
    bus.rd   = 1'b1;
    tick(1);
    chk(oe, eoe);
    chk(rdata & eoe, exp);
    bus.rd   = 1'b0;
    tick(1);
  endtask

  // Modes are static, so they only change while reset is held.
  task automatic hw_reset(input fdcr_mode_t m, input logic s);
    rstn = 1'b0;
    mode = m;
    swap = s;
    tick(4);
    rstn = 1'b1;
    tick(1);
  endtask

  task automatic wpulses(input int n);
    repeat (n) begin
      wp_n = 1'b0;
      tick(1);
      wp_n = 1'b1;
      tick(2);
    end
  endtask

  // Expected {select_n, motor_n} worked out from the decode tables.
  function automatic logic [7:0] decode(input logic [7:0] d, input logic s);
    logic [3:0] m;
    logic [1:0] c;
    m = d[7:4];
    c = d[1:0];
    if (s) begin
      m = {d[7:6], d[4], d[5]};
      c = (c < 2'h2) ? {1'b0, ~c[0]} : c;
    end
    decode = {m[c] ? ~(4'h1 << c) : 4'hf, ~m};
  endfunction

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial begin
    hw_reset(NATIVE_STATUS_MODE, 1'b0);
    tick(12);
    chk(pins, 8'hff);
    chk(8'(srst_n), 8'h00);
    chk(8'(dma_en), 8'h01);
    rd(DRV_CTRL_ADDR, 8'h00, 8'hff);
    rd(TAPE_SEL_ADDR, 8'h00, 8'h03);
    rd(STATUS_B_ADDR, 8'hc0, 8'hff);
    $display("test reset values done");

    // Each select code with its motor on, codes 0 and 1 also with it off, in both mappings, status B beside it.
    for (int s = 0; s < 2; s++) begin
      hw_reset(NATIVE_STATUS_MODE, s[0]);
      foreach (act[n]) begin
        wr(DRV_CTRL_ADDR, act[n]);
        tick(1);
        e = decode(act[n], s[0]);
        chk(pins, e);
        rd(STATUS_B_ADDR, {2'h3, act[n][0], 3'h0, ~e[1:0]}, 8'hff);
      end
    end
    $display("test drive decode done");

    // Soft reset by two back-to-back writes, other state kept.
    wr(TAPE_SEL_ADDR, 8'h02);
    wr(DRV_CTRL_ADDR, 8'h18);
    wr(DRV_CTRL_ADDR, 8'h1c);
    lo = 0;
    for (int i = 0; i < 40; i++) begin
      if (srst_n === 1'b0) begin
        lo++;
      end
      tick(1);
    end
    if (srst_n !== 1'b1) begin
      bad_count++;
      $display("FAIL t=%0t soft reset never released", $time);
    end
    chk(8'(lo >= 10), 8'h01);
    rd(DRV_CTRL_ADDR, 8'h1c, 8'hff);
    chk(pins, decode(8'h1c, 1'b1));
    rd(TAPE_SEL_ADDR, 8'h02, 8'h03);
    wr(DRV_CTRL_ADDR, 8'h14);
    tick(1);
    chk(8'(dma_en), 8'h01);
    $display("test soft reset done");

    // Tape codes, refused places and the plain-mode DMA gate.
    hw_reset(PLAIN_MODE, 1'b0);
    for (int v = 0; v < 4; v++) begin
      wr(TAPE_SEL_ADDR, {6'h3f, v[1:0]});
      rd(TAPE_SEL_ADDR, {6'h00, v[1:0]}, 8'h03);
      chk(8'(tape), 8'(v));
    end
    chk(8'(dma_en), 8'h00);
    wr(DRV_CTRL_ADDR, 8'h0c);
    tick(1);
    chk(8'(dma_en), 8'h01);
    wr(DRV_CTRL_ADDR, 8'h04);
    tick(1);
    chk(8'(dma_en), 8'h00);
    wr(STATUS_B_ADDR, 8'h55);
    rd(STATUS_B_ADDR, 8'h00, 8'h00);
    rd(10'h3f5, 8'h00, 8'h00);
    rd(DRV_CTRL_ADDR, 8'h04, 8'hff);
    $display("test tape and gating done");

    // Native toggles from fast then slow drive pulses and write pulses.
    hw_reset(NATIVE_STATUS_MODE, 1'b0);
    wr(DRV_CTRL_ADDR, 8'h1c);
    we = 1'b1;
    for (int k = 0; k < 2; k++) begin
      slow = k[0];
      spin = 1'b1;
      wpulses(3);
      tick(60);
      spin = 1'b0;
      tick(10);
      rd(STATUS_B_ADDR, {3'h6, ~k[0], rcount[0], 3'h5}, 8'hff);
    end
    we = 1'b0;
    $display("test native status done");

    // Compact latches, clear on the digital input read, selects shown.
    hw_reset(COMPACT_STATUS_MODE, 1'b0);
    present = 1'b1;
    wr(DRV_CTRL_ADDR, 8'h1c);
    tick(4);
    rd(STATUS_B_ADDR, 8'h43, 8'hff);
    spin = 1'b1;
    tick(20);
    spin = 1'b0;
    we = 1'b1;
    wpulses(2);
    tick(10);
    rd(STATUS_B_ADDR, 8'h5f, 8'hff);
    we = 1'b0;
    rd(DIG_INPUT_ADDR, 8'h00, 8'h00);
    rd(STATUS_B_ADDR, 8'h43, 8'hff);
    // Write enable rises in the very cycle of the clearing read.
    we = 1'b1;
    rd(DIG_INPUT_ADDR, 8'h00, 8'h00);
    rd(STATUS_B_ADDR, 8'h47, 8'hff);
    we = 1'b0;
    rd(DIG_INPUT_ADDR, 8'h00, 8'h00);
    wpulses(1);
    present = 1'b0;
    tick(6);
    rd(STATUS_B_ADDR, 8'hd3, 8'hff);
    $display("test compact status done");
    test_done();
  end
endmodule
`default_nettype wire
